// >>> ssb_pkg.sv
/*
 Package for the serial status and bit rate block: register offsets,
 status bit positions, reset values and prescaler codes.
 Assumes nothing of its surroundings.
*/
package ssb_pkg;
    localparam logic [3:0] SSB_OFF_STAT0  = 4'h0;
    localparam logic [3:0] SSB_OFF_RATE0  = 4'h1;
    localparam logic [3:0] SSB_OFF_MODE0  = 4'h2;
    localparam logic [3:0] SSB_OFF_STAT1  = 4'h4;
    localparam logic [3:0] SSB_OFF_RATE1  = 4'h5;
    localparam logic [3:0] SSB_OFF_MODE1  = 4'h6;
    localparam int         SSB_BIT_TXE    = 7;
    localparam int         SSB_BIT_RXF    = 6;
    localparam int         SSB_BIT_ORUN   = 5;
    localparam int         SSB_BIT_FRM    = 4;
    localparam int         SSB_BIT_PAR    = 3;
    localparam int         SSB_BIT_TRANSMIT_END_FLAG   = 2;
    localparam int         SSB_BIT_RXMP   = 1;
    localparam int         SSB_BIT_TXMP   = 0;
    localparam logic [7:0] SSB_STAT_RST   = 8'h84;
    localparam logic [7:0] SSB_RATE_RST   = 8'hFF;
    localparam logic [7:0] SSB_MODE_RST   = 8'h00;
    localparam logic [7:0] SSB_BASE_DIV   = 8'h3F;
    localparam logic [1:0] SSB_CH_CNT_M1  = 2'h1;
endpackage

// >>> ssb_top.sv
/*
 Serial status flags and bit rate generators for two channels.
 Assumes the frame shifters report receive and transmit events as one
 cycle pulses and that software uses single cycle read and write strobes.
*/
// Added by the designer: the placing of the registers and the strobed register port.
// Contract
// - Only first stop bit checked for framing.
// - Framing error loads data, receive-full untouched.
// - Framing error blocks receive; sync also transmit.
// - Parity mismatch sets parity error bit 3.
// - Parity error cleared by reset or read-then-write-zero.
// - Receive disable keeps parity and framing flags.
// - Parity error loads data, blocks like framing.
// - Transmit end set by reset, disable, last bit.
// - Transmit end cleared with transmit-empty clear.
// - Transmit end is read only.
// - Received multiprocessor bit captured, read only.
// - Receive disable keeps multiprocessor bit.
// - Bit 0 feeds transmit multiprocessor bit.
// - Divider and clock select set bit rate.
// - Divider read-writable, resets to all ones.
// - Each channel has its own rate generator.
// - Transmit-empty set on load, reset, disable.
// - Overrun keeps old data, drops new.
`timescale 1ns/100ps
module ssb_top
    import ssb_pkg::*;
#(
    parameter int CH = 2
)
(
    // System.
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         standby,
    // Register port.
    input  wire logic [3:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [7:0]   reg_rdata,
    // Per-channel control from the rest of the unit.
    input  wire logic [CH-1:0] rx_enable,
    input  wire logic [CH-1:0] tx_enable,
    input  wire logic [CH-1:0] sync_mode,
    input  wire logic [CH-1:0] multiproc_fmt,
    // Receive frame report from the receive shifter.
    input  wire logic [CH-1:0] rx_done,
    input  wire logic [CH-1:0] rx_stop1,
    input  wire logic [CH-1:0] rx_par_bad,
    input  wire logic [CH-1:0] rx_mp_bit,
    input  wire logic [CH*8-1:0] rx_char,
    // Transmit events from the transmit shifter.
    input  wire logic [CH-1:0] tx_load,
    input  wire logic [CH-1:0] tx_last_bit,
    // Outputs to the rest of the unit.
    output logic [CH*8-1:0]   rx_hold,
    output logic [CH-1:0]     rx_blocked,
    output logic [CH-1:0]     tx_blocked,
    output logic [CH-1:0]     tx_mp_out,
    output logic [CH-1:0]     baud_tick,
    output logic [CH-1:0]     tx_empty,
    output logic [CH-1:0]     tx_end
);
    logic [7:0] stat_r  [CH];
    logic [7:0] stat_nxt[CH];
    logic [7:0] seen_r  [CH];
    logic [7:0] seen_nxt[CH];
    logic [7:0] rate_r  [CH];
    logic [7:0] rate_nxt[CH];
    logic [7:0] mode_r  [CH];
    logic [7:0] mode_nxt[CH];
    logic [7:0] hold_r  [CH];
    logic [7:0] hold_nxt[CH];
    logic [7:0] ncnt_r  [CH];
    logic [7:0] ncnt_nxt[CH];
    logic [13:0] pcnt_r  [CH];
    logic [13:0] pcnt_nxt[CH];
    logic [CH-1:0] tick_nxt;
    logic [7:0] rdata_nxt;

    // Prescaler terminal count: 64 times 4 to the power n, minus one.
    function automatic logic [13:0] pre_top(input logic [1:0] n);
        pre_top = 14'({SSB_BASE_DIV, 6'h3F} >> (6 - 2 * int'(n)));
    endfunction

    function automatic logic sel(input logic [3:0] a, input int c,
                                 input logic [3:0] off0,
                                 input logic [3:0] off1);
        sel = (c == 0) ? (a == off0) : (a == off1);
    endfunction

    always_comb
    begin
        rdata_nxt = 8'h00;
        for (int c = 0; c < CH; c++)
        begin
            stat_nxt[c] = stat_r[c];
            seen_nxt[c] = seen_r[c];
            rate_nxt[c] = rate_r[c];
            mode_nxt[c] = mode_r[c];
            hold_nxt[c] = hold_r[c];
            ncnt_nxt[c] = ncnt_r[c];
            pcnt_nxt[c] = pcnt_r[c];
            tick_nxt[c] = 1'b0;
            // Bit rate: prescaler then divider of N plus one.
            if (pcnt_r[c] >= pre_top(mode_r[c][1:0]))
            begin
                pcnt_nxt[c] = 14'h0000;
                if (ncnt_r[c] >= rate_r[c])
                begin
                    ncnt_nxt[c] = 8'h00;
                    tick_nxt[c] = 1'b1;
                end
                else
                    ncnt_nxt[c] = ncnt_r[c] + 8'h01;
            end
            else
                pcnt_nxt[c] = pcnt_r[c] + 14'h0001;
            // Reads record which flags were seen set.
            if (reg_rd && sel(reg_addr, c, SSB_OFF_STAT0, SSB_OFF_STAT1))
            begin
                rdata_nxt = stat_r[c];
                seen_nxt[c] = seen_r[c] | stat_r[c];
            end
            if (reg_rd && sel(reg_addr, c, SSB_OFF_RATE0, SSB_OFF_RATE1))
                rdata_nxt = rate_r[c];
            if (reg_rd && sel(reg_addr, c, SSB_OFF_MODE0, SSB_OFF_MODE1))
                rdata_nxt = mode_r[c];
            if (reg_wr && sel(reg_addr, c, SSB_OFF_RATE0, SSB_OFF_RATE1))
            begin
                rate_nxt[c] = reg_wdata;
                ncnt_nxt[c] = 8'h00;
            end
            if (reg_wr && sel(reg_addr, c, SSB_OFF_MODE0, SSB_OFF_MODE1))
                mode_nxt[c] = {6'h00, reg_wdata[1:0]};
            // Status write: clear only flags seen set, zero written.
            if (reg_wr && sel(reg_addr, c, SSB_OFF_STAT0, SSB_OFF_STAT1))
            begin
                for (int b = SSB_BIT_PAR; b <= SSB_BIT_TXE; b++)
                    if (!reg_wdata[b] && seen_r[c][b])
                    begin
                        stat_nxt[c][b] = 1'b0;
                        seen_nxt[c][b] = 1'b0;
                    end
                if (!reg_wdata[SSB_BIT_TXE] && seen_r[c][SSB_BIT_TXE])
                    stat_nxt[c][SSB_BIT_TRANSMIT_END_FLAG] = 1'b0;
                stat_nxt[c][SSB_BIT_TXMP] = reg_wdata[SSB_BIT_TXMP];
            end
            // Hardware events win over software clears.
            if (tx_load[c])
                stat_nxt[c][SSB_BIT_TXE] = 1'b1;
            if (tx_last_bit[c] && stat_r[c][SSB_BIT_TXE])
                stat_nxt[c][SSB_BIT_TRANSMIT_END_FLAG] = 1'b1;
            if (!tx_enable[c])
            begin
                stat_nxt[c][SSB_BIT_TXE] = 1'b1;
                stat_nxt[c][SSB_BIT_TRANSMIT_END_FLAG] = 1'b1;
            end
            // Receive disable leaves error and multiprocessor flags.
            if (rx_done[c] && rx_enable[c] && !rx_blocked[c])
            begin
                if (stat_r[c][SSB_BIT_RXF])
                    stat_nxt[c][SSB_BIT_ORUN] = 1'b1;
                else
                begin
                    hold_nxt[c] = rx_char[c*8 +: 8];
                    if (!sync_mode[c] && multiproc_fmt[c])
                        stat_nxt[c][SSB_BIT_RXMP] = rx_mp_bit[c];
                    if (!sync_mode[c] && !rx_stop1[c])
                        stat_nxt[c][SSB_BIT_FRM] = 1'b1;
                    if (!sync_mode[c] && rx_par_bad[c])
                        stat_nxt[c][SSB_BIT_PAR] = 1'b1;
                    if (sync_mode[c] || (rx_stop1[c] && !rx_par_bad[c]))
                        stat_nxt[c][SSB_BIT_RXF] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || standby)
        begin
            for (int c = 0; c < CH; c++)
            begin
                stat_r[c] <= SSB_STAT_RST;
                seen_r[c] <= 8'h00;
                rate_r[c] <= SSB_RATE_RST;
                mode_r[c] <= SSB_MODE_RST;
                hold_r[c] <= 8'h00;
                ncnt_r[c] <= 8'h00;
                pcnt_r[c] <= 14'h0000;
            end
            baud_tick <= '0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            stat_r    <= stat_nxt;
            seen_r    <= seen_nxt;
            rate_r    <= rate_nxt;
            mode_r    <= mode_nxt;
            hold_r    <= hold_nxt;
            ncnt_r    <= ncnt_nxt;
            pcnt_r    <= pcnt_nxt;
            baud_tick <= tick_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // Derived outputs, taken from flip-flops; tx_blocked is also gated by the sync_mode input.
    always_comb
    begin
        for (int c = 0; c < CH; c++)
        begin
            rx_hold[c*8 +: 8] = hold_r[c];
            rx_blocked[c] = |stat_r[c][SSB_BIT_ORUN:SSB_BIT_PAR];
            tx_blocked[c] = sync_mode[c] && rx_blocked[c];
            tx_mp_out[c]  = stat_r[c][SSB_BIT_TXMP];
            tx_empty[c]   = stat_r[c][SSB_BIT_TXE];
            tx_end[c]     = stat_r[c][SSB_BIT_TRANSMIT_END_FLAG];
        end
    end

    chk_rate_reset: assert property (@(posedge mclk)
        $past(sys_rst) |-> rate_r[0] == SSB_RATE_RST)
        else $error("Divider not all ones after reset.");
    chk_transmit_end_flag_ro: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == SSB_OFF_STAT0 && reg_wdata[SSB_BIT_TRANSMIT_END_FLAG]
         && !stat_r[0][SSB_BIT_TRANSMIT_END_FLAG] && tx_enable[0] && !tx_last_bit[0])
        |=> !stat_r[0][SSB_BIT_TRANSMIT_END_FLAG])
        else $error("Transmit end was written.");
    chk_perr_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_done[0] && rx_enable[0] && !rx_blocked[0] && !sync_mode[0]
         && rx_par_bad[0] && !stat_r[0][SSB_BIT_RXF] && !standby)
        |=> stat_r[0][SSB_BIT_PAR] && !stat_r[0][SSB_BIT_RXF])
        else $error("Parity error not flagged.");
    chk_ovr_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_done[0] && rx_enable[0] && !rx_blocked[0]
         && stat_r[0][SSB_BIT_RXF] && !standby)
        |=> stat_r[0][SSB_BIT_ORUN] && $stable(hold_r[0]))
        else $error("Overrun did not keep old data.");
    chk_txe_dis: assert property (@(posedge mclk) disable iff (sys_rst)
        (!tx_enable[0] && !standby) |=> tx_empty[0] && tx_end[0])
        else $error("Disable did not set empty and end.");

    chk_frm_load: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_done[0] && rx_enable[0] && !rx_blocked[0] && !sync_mode[0]
         && !rx_stop1[0] && !stat_r[0][SSB_BIT_RXF] && !standby)
        |=> stat_r[0][SSB_BIT_FRM] && !stat_r[0][SSB_BIT_RXF]
            && hold_r[0] == $past(rx_char[7:0]))
        else $error("Framing error did not load data alone.");

    chk_rx_block: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_blocked[0] && rx_done[0] && !standby)
        |=> $stable(hold_r[0]))
        else $error("Blocked receiver took a frame.");

    chk_rxdis_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        (!rx_enable[0] && !standby
         && !(reg_wr && reg_addr == SSB_OFF_STAT0))
        |=> $stable(stat_r[0][SSB_BIT_FRM:SSB_BIT_PAR])
            && $stable(stat_r[0][SSB_BIT_RXMP]))
        else $error("Receive disable changed error flags.");

    chk_transmit_end_flag_clr: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == SSB_OFF_STAT0 && !reg_wdata[SSB_BIT_TXE]
         && seen_r[0][SSB_BIT_TXE] && tx_enable[0] && !tx_last_bit[0]
         && !standby)
        |=> !tx_end[0])
        else $error("Transmit end not cleared with empty flag.");

    chk_mpt_wr: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == SSB_OFF_STAT0 && !standby)
        |=> tx_mp_out[0] == $past(reg_wdata[SSB_BIT_TXMP]))
        else $error("Transmit multiprocessor bit not written.");

    chk_rate_wr: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == SSB_OFF_RATE0 && !standby)
        |=> rate_r[0] == $past(reg_wdata))
        else $error("Divider write did not land.");

    chk_mp_ro: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == SSB_OFF_STAT0 && !rx_done[0] && !standby)
        |=> $stable(stat_r[0][SSB_BIT_RXMP]))
        else $error("Received multiprocessor bit was written.");

    chk_tick_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        (baud_tick[0] && !standby)
        |=> !baud_tick[0])
        else $error("Rate tick lasted more than one cycle.");

    chk_txe_load: assert property (@(posedge mclk) disable iff (sys_rst)
        (tx_load[0] && !standby)
        |=> tx_empty[0])
        else $error("Load did not set transmit empty.");
endmodule

// >>> ssb_far_end.sv
/*
 Model of the receive and transmit shifters beside the status block.
 Assumes the testbench calls its tasks one at a time from one process.
*/
`timescale 1ns/100ps
module ssb_far_end
(
    // Clock.
    input  wire logic        mclk,
    // Frame reports and transmit events.
    output logic      [1:0]  rx_done,
    output logic      [1:0]  rx_stop1,
    output logic      [1:0]  rx_par_bad,
    output logic      [1:0]  rx_mp_bit,
    output logic      [15:0] rx_char,
    output logic      [1:0]  tx_load,
    output logic      [1:0]  tx_last_bit
);
    initial
    begin
        {rx_done, rx_stop1, rx_par_bad, rx_mp_bit} = 8'h00;
        {rx_char, tx_load, tx_last_bit} = 20'h00000;
    end

    // Reports one finished frame; data lines scramble outside frames.
    task automatic frame(input int c, input logic [7:0] d,
                         input logic stp, input logic pb, input logic mp);
        @(posedge mclk);
        rx_done[c] <= 1'h1;
        rx_stop1[c] <= stp;
        rx_par_bad[c] <= pb;
        rx_mp_bit[c] <= mp;
        rx_char[c*8 +: 8] <= d;
        @(posedge mclk);
        rx_done <= 2'h0;
        rx_char <= ~rx_char;
        rx_mp_bit <= ~rx_mp_bit;
    endtask

    // Pulses the load or last bit event of one channel.
    task automatic tx_event(input int c, input logic ld, input logic lb);
        @(posedge mclk);
        tx_load[c] <= ld;
        tx_last_bit[c] <= lb;
        @(posedge mclk);
        tx_load <= 2'h0;
        tx_last_bit <= 2'h0;
    endtask
endmodule

// >>> ssb_top_test.sv
/*
 Self-checking testbench for the serial status and bit rate block.
 Assumes the far end model and the block's package are compiled first.
*/
`timescale 1ns/100ps
module ssb_top_test;
    import ssb_pkg::*;
    logic        mclk, sys_rst, standby, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [1:0]  rx_enable, tx_enable, sync_mode, multiproc_fmt;
    logic [1:0]  rx_done, rx_stop1, rx_par_bad, rx_mp_bit;
    logic [1:0]  tx_load, tx_last_bit, rx_blocked, tx_blocked;
    logic [1:0]  tx_mp_out, baud_tick, tx_empty, tx_end;
    logic [15:0] rx_char, rx_hold;
    int          miscompares, checked, n;

    ssb_top #(.CH(2)) DUT (.mclk(mclk), .sys_rst(sys_rst),
        .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_enable(rx_enable), .tx_enable(tx_enable),
        .sync_mode(sync_mode), .multiproc_fmt(multiproc_fmt),
        .rx_done(rx_done), .rx_stop1(rx_stop1), .rx_par_bad(rx_par_bad),
        .rx_mp_bit(rx_mp_bit), .rx_char(rx_char), .tx_load(tx_load),
        .tx_last_bit(tx_last_bit), .rx_hold(rx_hold),
        .rx_blocked(rx_blocked), .tx_blocked(tx_blocked),
        .tx_mp_out(tx_mp_out), .baud_tick(baud_tick),
        .tx_empty(tx_empty), .tx_end(tx_end));
    ssb_far_end far (.mclk(mclk), .rx_done(rx_done), .rx_stop1(rx_stop1),
        .rx_par_bad(rx_par_bad), .rx_mp_bit(rx_mp_bit), .rx_char(rx_char),
        .tx_load(tx_load), .tx_last_bit(tx_last_bit));

    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic check_gap(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        check_reg(reg_rdata, exp);
    endtask

    // Counts clock cycles between two rate ticks of one channel.
    task automatic gap(input int c, input int exp);
        int k;
        k = 0;
        while (baud_tick[c] !== 1'h1 && k < 20000)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        k = 0;
        do
        begin
            @(posedge mclk);
            #1;
            k++;
        end while (baud_tick[c] !== 1'h1 && k < 20000);
        check_gap(k, exp);
    endtask

    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #(25 * 60000);
        miscompares++;
        conclude();
    end

    initial
    begin
        {sys_rst, standby, reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h8000;
        {rx_enable, sync_mode, tx_enable, multiproc_fmt} = 8'h0D;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'h0;
        rd(SSB_OFF_STAT0, 8'h84);
        rd(SSB_OFF_RATE0, 8'hFF);
        rd(4'h3, 8'h00);
        wr(SSB_OFF_RATE0, 8'h5A);
        wr(SSB_OFF_RATE1, 8'hA5);
        rd(SSB_OFF_RATE0, 8'h5A);
        rd(SSB_OFF_RATE1, 8'hA5);
        for (n = 0; n < 4; n++)
        begin
            wr(SSB_OFF_MODE0, n[7:0]);
            wr(SSB_OFF_RATE0, 8'h01);
            gap(0, 128 << (2 * n));
        end
        wr(SSB_OFF_RATE1, 8'h00);
        gap(1, 64);
        @(posedge mclk);
        rx_enable <= 2'h3;
        far.frame(0, 8'h3C, 1'h1, 1'h0, 1'h1);
        rd(SSB_OFF_STAT0, 8'hC6);
        far.frame(0, 8'h55, 1'h1, 1'h0, 1'h1);
        rd(SSB_OFF_STAT0, 8'hE6);
        check_reg(rx_hold[7:0], 8'h3C);
        wr(SSB_OFF_STAT0, 8'h80);
        rd(SSB_OFF_STAT0, 8'h86);
        far.frame(0, 8'hAA, 1'h0, 1'h0, 1'h1);
        far.frame(0, 8'h11, 1'h1, 1'h0, 1'h1);
        rd(SSB_OFF_STAT0, 8'h96);
        check_reg(rx_hold[7:0], 8'hAA);
        check_reg({7'h00, rx_blocked[0]}, 8'h01);
        sync_mode <= 2'h1;
        @(posedge mclk);
        #1;
        check_reg({7'h00, tx_blocked[0]}, 8'h01);
        sync_mode <= 2'h0;
        rx_enable <= 2'h2;
        rd(SSB_OFF_STAT0, 8'h96);
        rx_enable <= 2'h3;
        wr(SSB_OFF_STAT0, 8'h80);
        far.frame(0, 8'h77, 1'h1, 1'h1, 1'h1);
        wr(SSB_OFF_STAT0, 8'h80);
        rd(SSB_OFF_STAT0, 8'h8E);
        check_reg(rx_hold[7:0], 8'h77);
        wr(SSB_OFF_STAT0, 8'h80);
        wr(SSB_OFF_STAT0, 8'hFF);
        rd(SSB_OFF_STAT0, 8'h87);
        check_reg({7'h00, tx_mp_out[0]}, 8'h01);
        wr(SSB_OFF_STAT0, 8'h80);
        rx_enable <= 2'h2;
        far.frame(0, 8'h22, 1'h1, 1'h0, 1'h0);
        rd(SSB_OFF_STAT0, 8'h86);
        rx_enable <= 2'h3;
        wr(SSB_OFF_STAT0, 8'h00);
        wr(SSB_OFF_STAT0, 8'h04);
        rd(SSB_OFF_STAT0, 8'h02);
        check_reg({6'h00, tx_empty[0], tx_end[0]}, 8'h00);
        far.tx_event(0, 1'h1, 1'h0);
        rd(SSB_OFF_STAT0, 8'h82);
        far.tx_event(0, 1'h0, 1'h1);
        rd(SSB_OFF_STAT0, 8'h86);
        wr(SSB_OFF_STAT0, 8'h00);
        tx_enable <= 2'h2;
        rd(SSB_OFF_STAT0, 8'h86);
        tx_enable <= 2'h3;
        far.frame(0, 8'h66, 1'h1, 1'h1, 1'h1);
        @(posedge mclk);
        standby <= 1'h1;
        @(posedge mclk);
        standby <= 1'h0;
        rd(SSB_OFF_STAT0, 8'h84);
        rd(SSB_OFF_RATE0, 8'hFF);
        rd(SSB_OFF_STAT1, 8'h84);
        conclude();
    end
endmodule
